// ===== hdl/uart_line_ctrl.sv
/*
 * Line control around one UART channel: transmit serializer with pause/resume flow control,
 * RS-485 driver-enable timing, multidrop address matching and half-duplex receive blanking.
 * Assumes the TX FIFO feeds bytes by valid/ready, the receive shift register hands over whole
 * characters as one-cycle strobes with the ninth or parity bit in b8, and configuration is
 * only changed while the channel is disabled.
 */
`timescale 1ns/100ps
`include "uart_line_ctrl_map.svh"

module uart_line_ctrl #(
    parameter int CLKS_PER_BIT = `CLK_FREQ_HZ / `BAUD_DEFAULT
) (
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire uart_line_ctrl_pkg::line_cfg_t cfg,
    input  wire logic                          tx_byte_valid,
    output logic                               tx_byte_ready,
    input  wire logic [7:0]                    tx_byte,
    output logic                               tx_line,
    output logic                               driver_enable_out,
    output logic                               tx_busy,
    input  wire logic                          rx_char_valid,
    input  wire uart_line_ctrl_pkg::char9_t    rx_char,
    output logic                               rx_out_valid,
    input  wire logic                          rx_out_ready,
    output uart_line_ctrl_pkg::char9_t         rx_out_char,
    output logic                               tx_paused,
    output logic                               addr_matched,
    output logic                               rx_disabled,
    output logic                               rx_overrun,
    input  wire logic                          rx_overrun_clear
);

    localparam logic [15:0] BIT_RELOAD = 16'(CLKS_PER_BIT - 1);

    logic [1:0]                    rst_sync_reg;
    logic                          rst_int_b;

    uart_line_ctrl_pkg::tx_state_t state_reg;
    uart_line_ctrl_pkg::tx_state_t state_next;
    logic [15:0]                   bit_cnt_reg;
    logic [15:0]                   bit_cnt_next;
    logic [3:0]                    bit_idx_reg;
    logic [3:0]                    bit_idx_next;
    logic [3:0]                    hold_cnt_reg;
    logic [3:0]                    hold_cnt_next;
    logic [8:0]                    shift_reg;
    logic [8:0]                    shift_next;
    uart_line_ctrl_pkg::char9_t    hold_reg;
    uart_line_ctrl_pkg::char9_t    hold_next;
    logic                          hold_full_reg;
    logic                          hold_full_next;
    logic                          half_byte_reg;
    logic                          half_byte_next;
    logic                          ready_reg;
    logic                          ready_next;
    logic                          line_reg;
    logic                          line_next;
    logic                          de_reg;
    logic                          de_next;
    logic                          busy_reg;
    logic                          busy_next;

    logic                          paused_reg;
    logic                          paused_next;
    logic                          matched_reg;
    logic                          matched_next;
    logic                          rx_off_reg;
    logic                          rx_off_next;
    logic                          overrun_reg;
    logic                          overrun_next;

    logic                          bit_tick;
    logic                          rs485_on;
    logic                          sw_flow_on;
    logic                          multidrop_on;
    logic                          tx_allowed;
    logic                          take_char;
    logic                          take_byte;
    logic [3:0]                    data_last;
    logic                          hit_pause;
    logic                          hit_resume;
    logic                          push_valid;
    logic                          push_ready;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_sync_reg <= `RESET_SYNC_ZERO;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_int_b = rst_sync_reg[1];

    char_match #(.WIDTH(8)) pause_match (
        .rx_char  (rx_char.data),
        .ref_char (cfg.pause_char),
        .hit      (hit_pause)
    );

    char_match #(.WIDTH(8)) resume_match (
        .rx_char  (rx_char.data),
        .ref_char (cfg.resume_char),
        .hit      (hit_resume)
    );

    always_comb
    begin
        sw_flow_on   = (cfg.flow_mode == `FLOW_MODE_PAUSE_RESUME);
        multidrop_on = (cfg.flow_mode == `FLOW_MODE_ADDR_OPEN)
                    || (cfg.flow_mode == `FLOW_MODE_ADDR_GATED);
        rs485_on     = (cfg.pin_mode == `PIN_MODE_DIR_A) || (cfg.pin_mode == `PIN_MODE_DIR_B);
        // Mode 3 sends freely, mode 4 only after a match, pause/resume holds while paused.
        tx_allowed   = !(sw_flow_on && paused_reg)
                    && !((cfg.flow_mode == `FLOW_MODE_ADDR_GATED) && !matched_reg);
        data_last    = cfg.nine_bit ? `DATA_LAST_9 : `DATA_LAST_8;
        bit_tick     = (bit_cnt_reg == 16'h0000);
    end

    // Transmit byte intake: wide nine-bit mode pairs two bytes into one character.
    always_comb
    begin
        take_char      = 1'b0;
        take_byte      = tx_byte_valid && ready_reg;
        hold_next      = hold_reg;
        hold_full_next = hold_full_reg;
        half_byte_next = half_byte_reg;
        if (take_byte)
        begin
            if (cfg.nine_bit && cfg.wide_mode && !half_byte_reg)
            begin
                hold_next.data = tx_byte;
                half_byte_next = 1'b1;
            end
            else if (half_byte_reg)
            begin
                hold_next.b8   = tx_byte[0];
                half_byte_next = 1'b0;
                hold_full_next = 1'b1;
            end
            else
            begin
                hold_next      = '{b8: 1'b0, data: tx_byte};
                hold_full_next = 1'b1;
            end
        end
        state_next    = state_reg;
        bit_cnt_next  = bit_tick ? BIT_RELOAD : bit_cnt_reg - 16'h0001;
        bit_idx_next  = bit_idx_reg;
        hold_cnt_next = hold_cnt_reg;
        shift_next    = shift_reg;
        case (state_reg)
            uart_line_ctrl_pkg::TX_IDLE:
            begin
                bit_cnt_next = BIT_RELOAD;
                if (hold_full_reg && tx_allowed)
                begin
                    take_char  = 1'b1;
                    state_next = rs485_on ? uart_line_ctrl_pkg::TX_LEAD : uart_line_ctrl_pkg::TX_START;
                end
            end
            uart_line_ctrl_pkg::TX_LEAD:
            begin
                if (bit_tick)
                begin
                    state_next = uart_line_ctrl_pkg::TX_START;
                end
            end
            uart_line_ctrl_pkg::TX_START:
            begin
                if (bit_tick)
                begin
                    state_next   = uart_line_ctrl_pkg::TX_DATA;
                    bit_idx_next = 4'h0;
                end
            end
            uart_line_ctrl_pkg::TX_DATA:
            begin
                if (bit_tick)
                begin
                    bit_idx_next = bit_idx_reg + 4'h1;
                    shift_next   = {1'b0, shift_reg[8:1]};
                    if (bit_idx_reg == data_last)
                    begin
                        state_next = uart_line_ctrl_pkg::TX_STOP;
                    end
                end
            end
            uart_line_ctrl_pkg::TX_STOP, uart_line_ctrl_pkg::TX_HOLD:
            begin
                if (bit_tick)
                begin
                    // The flow gate is checked only between characters, so a pause never cuts one.
                    if (hold_full_reg && tx_allowed)
                    begin
                        take_char  = 1'b1;
                        state_next = uart_line_ctrl_pkg::TX_START;
                    end
                    else if (state_reg == uart_line_ctrl_pkg::TX_STOP)
                    begin
                        hold_cnt_next = cfg.turnaround_delay;
                        state_next    = (cfg.turnaround_delay == `DELAY_NONE)
                                      ? uart_line_ctrl_pkg::TX_IDLE : uart_line_ctrl_pkg::TX_HOLD;
                    end
                    else
                    begin
                        hold_cnt_next = hold_cnt_reg - 4'h1;
                        if (hold_cnt_reg == 4'h1)
                        begin
                            state_next = uart_line_ctrl_pkg::TX_IDLE;
                        end
                    end
                end
            end
            default:
            begin
                state_next = uart_line_ctrl_pkg::TX_IDLE;
            end
        endcase
        if (take_char)
        begin
            shift_next = {hold_reg.b8, hold_reg.data};
            if (!take_byte || half_byte_reg || (cfg.nine_bit && cfg.wide_mode))
            begin
                hold_full_next = take_byte && half_byte_reg;
            end
        end
        ready_next = !hold_full_next;
        busy_next  = (state_next == uart_line_ctrl_pkg::TX_START)
                  || (state_next == uart_line_ctrl_pkg::TX_DATA)
                  || (state_next == uart_line_ctrl_pkg::TX_STOP);
        case (state_next)
            uart_line_ctrl_pkg::TX_START: line_next = 1'b0;
            uart_line_ctrl_pkg::TX_DATA:  line_next = shift_next[0];
            default:                      line_next = 1'b1;
        endcase
        de_next = !(rs485_on && (state_next != uart_line_ctrl_pkg::TX_IDLE)) ^ cfg.de_polarity;
    end

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            state_reg     <= uart_line_ctrl_pkg::TX_IDLE;
            bit_cnt_reg   <= 16'h0000;
            bit_idx_reg   <= 4'h0;
            hold_cnt_reg  <= 4'h0;
            shift_reg     <= 9'h000;
            hold_reg      <= '0;
            hold_full_reg <= 1'b0;
            half_byte_reg <= 1'b0;
            ready_reg     <= 1'b0;
            line_reg      <= 1'b1;
            de_reg        <= 1'b0;
            busy_reg      <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            bit_cnt_reg   <= bit_cnt_next;
            bit_idx_reg   <= bit_idx_next;
            hold_cnt_reg  <= hold_cnt_next;
            shift_reg     <= shift_next;
            hold_reg      <= hold_next;
            hold_full_reg <= hold_full_next;
            half_byte_reg <= half_byte_next;
            ready_reg     <= ready_next;
            line_reg      <= line_next;
            de_reg        <= de_next;
            busy_reg      <= busy_next;
        end
    end

    // Receive side: blanking, pause/resume detection and address filtering.
    always_comb
    begin
        paused_next  = paused_reg;
        matched_next = matched_reg;
        rx_off_next  = rx_off_reg;
        push_valid   = 1'b0;
        overrun_next = overrun_reg && !rx_overrun_clear;
        if (rx_char_valid && !(cfg.half_duplex && busy_reg))
        begin
            if (multidrop_on && rx_char.b8)
            begin
                // Address bytes are never stored, matched or not.
                if (hit_resume || hit_pause)
                begin
                    matched_next = 1'b1;
                    rx_off_next  = 1'b0;
                end
                else
                begin
                    matched_next = 1'b0;
                    rx_off_next  = 1'b1;
                end
            end
            else
            begin
                push_valid = !(multidrop_on && rx_off_reg);
                if (sw_flow_on && hit_pause)
                begin
                    paused_next = 1'b1;
                end
                else if (sw_flow_on && hit_resume)
                begin
                    paused_next = 1'b0;
                end
            end
        end
        if (push_valid && !push_ready)
        begin
            overrun_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            paused_reg  <= 1'b0;
            matched_reg <= 1'b0;
            rx_off_reg  <= 1'b0;
            overrun_reg <= 1'b0;
        end
        else
        begin
            paused_reg  <= paused_next;
            matched_reg <= matched_next;
            rx_off_reg  <= rx_off_next;
            overrun_reg <= overrun_next;
        end
    end

    two_entry_buffer #(.WIDTH(9)) rx_buffer (
        .clk       (clk),
        .rst_b     (rst_int_b),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (rx_char),
        .out_valid (rx_out_valid),
        .out_ready (rx_out_ready),
        .out_data  (rx_out_char)
    );

    assign tx_byte_ready     = ready_reg;
    assign tx_line           = line_reg;
    assign driver_enable_out = de_reg;
    assign tx_busy           = busy_reg;
    assign tx_paused         = paused_reg;
    assign addr_matched      = matched_reg;
    assign rx_disabled       = rx_off_reg;
    assign rx_overrun        = overrun_reg;

endmodule : uart_line_ctrl

// ===== hdl/uart_line_ctrl_map.svh
/*
 * Named constants of the UART line-control block: mode encodings, field values and timing.
 * Assumes inclusion by bare name from design files that need these figures.
 */
`ifndef UART_LINE_CTRL_MAP_SVH
`define UART_LINE_CTRL_MAP_SVH

`define FLOW_MODE_PAUSE_RESUME  3'h2
`define FLOW_MODE_ADDR_OPEN     3'h3
`define FLOW_MODE_ADDR_GATED    3'h4
`define PIN_MODE_DIR_A          3'h3
`define PIN_MODE_DIR_B          3'h4
`define CLK_FREQ_HZ             25000000
`define BAUD_DEFAULT            115200
`define DATA_LAST_8             4'h7
`define DATA_LAST_9             4'h8
`define DELAY_NONE              4'h0
`define RESET_SYNC_ZERO         2'h0

`endif

// ===== hdl/uart_line_ctrl_pkg.sv
/*
 * Types shared by the UART line-control block: character, configuration and transmitter states.
 * Assumes nothing of its surroundings.
 */
package uart_line_ctrl_pkg;

    typedef struct packed {
        logic       b8;
        logic [7:0] data;
    } char9_t;

    typedef struct packed {
        logic [2:0] flow_mode;
        logic       half_duplex;
        logic [2:0] pin_mode;
        logic       de_polarity;
        logic [3:0] turnaround_delay;
        logic [7:0] resume_char;
        logic [7:0] pause_char;
        logic       nine_bit;
        logic       wide_mode;
    } line_cfg_t;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_LEAD  = 3'h1,
        TX_START = 3'h3,
        TX_DATA  = 3'h2,
        TX_STOP  = 3'h6,
        TX_HOLD  = 3'h7
    } tx_state_t;

endpackage : uart_line_ctrl_pkg

// ===== hdl/char_match.sv
/*
 * Compares a received character with one programmed character.
 * Assumes both operands are stable in the cycle of use.
 */
`timescale 1ns/100ps

module char_match #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] rx_char,
    input  wire logic [WIDTH-1:0] ref_char,
    output logic                  hit
);

    always_comb
    begin
        hit = (rx_char == ref_char);
    end

endmodule : char_match

// ===== hdl/two_entry_buffer.sv
/*
 * Two-entry buffer with valid and ready on both sides; valid comes from a flip-flop, ready is decoded from the count.
 * Assumes an asynchronous active-low reset whose release the caller has already synchronised.
 */
`timescale 1ns/100ps

module two_entry_buffer #(
    parameter int WIDTH = 9
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    logic [1:0]       count_reg;
    logic [1:0]       count_next;
    logic [WIDTH-1:0] slot0_reg;
    logic [WIDTH-1:0] slot0_next;
    logic [WIDTH-1:0] slot1_reg;
    logic [WIDTH-1:0] slot1_next;
    logic             push;
    logic             pop;
    logic             valid_reg;

    always_comb
    begin
        push       = in_valid && (count_reg != 2'h2);
        pop        = out_ready && (count_reg != 2'h0);
        count_next = count_reg;
        slot0_next = slot0_reg;
        slot1_next = slot1_reg;
        if (pop)
        begin
            slot0_next = slot1_reg;
            count_next = count_next - 2'h1;
        end
        if (push)
        begin
            if (count_next == 2'h0)
            begin
                slot0_next = in_data;
            end
            else
            begin
                slot1_next = in_data;
            end
            count_next = count_next + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_reg <= 2'h0;
            slot0_reg <= '0;
            slot1_reg <= '0;
            valid_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            slot0_reg <= slot0_next;
            slot1_reg <= slot1_next;
            valid_reg <= (count_next != 2'h0);
        end
    end

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = valid_reg;
    assign out_data  = slot0_reg;

endmodule : two_entry_buffer

// ===== bench/line_ctrl_checker.sv
/* Concurrent checks on the line-control ports.
   Assumes the raw clk and rst_b of the top module. */
`timescale 1ns/100ps
module line_ctrl_checker #(
    parameter int CLKS_PER_BIT = 4
) (
    input wire logic                          clk,
    input wire logic                          rst_b,
    input wire uart_line_ctrl_pkg::line_cfg_t cfg,
    input wire logic                          tx_busy,
    input wire logic                          driver_enable_out,
    input wire logic                          rx_char_valid,
    input wire uart_line_ctrl_pkg::char9_t    rx_char,
    input wire logic                          rx_out_valid,
    input wire logic                          tx_paused,
    input wire logic                          addr_matched,
    input wire logic                          rx_disabled
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic       rs, md, act, adr, hit;
    logic [7:0] idle_reg;
    assign rs = cfg.pin_mode == 3'h3 || cfg.pin_mode == 3'h4;
    assign md = cfg.flow_mode == 3'h3 || cfg.flow_mode == 3'h4;
    assign act = driver_enable_out == cfg.de_polarity;
    assign adr = rx_char_valid && md && rx_char.b8 && !(cfg.half_duplex && tx_busy);
    assign hit = rx_char.data == cfg.resume_char || rx_char.data == cfg.pause_char;
    // Counts idle cycles with the driver still enabled.
    always_ff @(posedge clk or negedge rst_b) idle_reg <= (!rst_b || tx_busy || !act) ? 8'h00 : idle_reg + 8'h01;
    property p_pause; rx_char_valid && cfg.flow_mode == 3'h2 && rx_char.data == cfg.pause_char
        && !(cfg.half_duplex && tx_busy) |=> tx_paused; endproperty
    a_pause: assert property (p_pause) else $error("pause ignored");
    property p_resume; rx_char_valid && cfg.flow_mode == 3'h2 && rx_char.data == cfg.resume_char
        && !(cfg.half_duplex && tx_busy) |=> !tx_paused; endproperty
    a_resume: assert property (p_resume) else $error("resume ignored");
    property p_lead; rs && $rose(tx_busy) |-> $past(act) && act; endproperty
    a_lead: assert property (p_lead) else $error("driver late");
    property p_hold; rs && $fell(tx_busy) && cfg.turnaround_delay != 4'h0 |-> act [*4]; endproperty
    a_hold: assert property (p_hold) else $error("driver dropped early");
    property p_cnt; rs && act && !tx_busy |-> int'(idle_reg) <= CLKS_PER_BIT * (int'(cfg.turnaround_delay) + 1) + 2;
    endproperty
    a_cnt: assert property (p_cnt) else $error("driver held too long");
    property p_zero; rs && $fell(tx_busy) && cfg.turnaround_delay == 4'h0 |-> ##[0:2] !act; endproperty
    a_zero: assert property (p_zero) else $error("driver not released");
    property p_hd; rx_char_valid && cfg.half_duplex && tx_busy && !rx_out_valid |=> !rx_out_valid; endproperty
    a_hd: assert property (p_hd) else $error("echo stored");
    property p_match; adr && hit |=> addr_matched && !rx_disabled && !rx_out_valid; endproperty
    a_match: assert property (p_match) else $error("address missed");
    property p_miss; adr && !hit |=> rx_disabled && !addr_matched; endproperty
    a_miss: assert property (p_miss) else $error("receiver kept");
    property p_gate; cfg.flow_mode == 3'h4 && !addr_matched |=> !$rose(tx_busy); endproperty
    a_gate: assert property (p_gate) else $error("sent unmatched");
    c_de: cover property (rs && $fell(tx_busy));
    c_pause: cover property ($rose(tx_paused));
    c_miss: cover property ($rose(rx_disabled));
endmodule : line_ctrl_checker

bind uart_line_ctrl line_ctrl_checker #(.CLKS_PER_BIT(CLKS_PER_BIT)) chk (.clk(clk), .rst_b(rst_b), .cfg(cfg),
    .tx_busy(tx_busy), .driver_enable_out(driver_enable_out), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_out_valid(rx_out_valid), .tx_paused(tx_paused), .addr_matched(addr_matched), .rx_disabled(rx_disabled));

// ===== bench/remote_uart.sv
/* Remote UART: decodes the serial output and injects received characters.
   Assumes CPB clocks per bit and one stop bit. */
`timescale 1ns/100ps
module remote_uart #(
    parameter int CPB = 4
) (
    input  wire logic                  clk,
    input  wire logic                  tx_line,
    input  wire logic                  nine,
    output logic                       rx_char_valid,
    output uart_line_ctrl_pkg::char9_t rx_char
);
    logic [9:0] got[$];
    logic [9:0] v;
    initial
    begin
        rx_char_valid = 1'b0;
        rx_char = '0;
    end
    task automatic send(input uart_line_ctrl_pkg::char9_t c);
        @(posedge clk);
        #1;
        rx_char_valid = 1'b1;
        rx_char = c;
        @(posedge clk);
        #1;
        rx_char_valid = 1'b0;
        rx_char = ~c; // Stale data is scrambled once the strobe ends.
    endtask : send
    always
    begin
        @(negedge tx_line);
        v = '0;
        repeat (CPB / 2) @(posedge clk);
        for (int i = 0; i < 9 + int'(nine); i++)
        begin
            repeat (CPB) @(posedge clk);
            if (i < 8 + int'(nine))
                v[i] = tx_line;
            else
                v[9] = tx_line;
        end
        got.push_back(v);
    end
endmodule : remote_uart

// ===== bench/tb.sv
/* Self-checking bench of the line-control block against a remote UART model.
   Assumes a bit period shortened to four clocks. */
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb;
    localparam int CPB = 4;
    logic       clk, rst_b, tx_byte_valid, tx_byte_ready, tx_line, de, tx_busy, rx_char_valid, rx_out_valid;
    logic       rx_out_ready, tx_paused, addr_matched, rx_disabled, rx_overrun, rx_overrun_clear;
    logic [7:0] tx_byte;
    logic [9:0] g;
    int         errors, checks_done, cyc;
    uart_line_ctrl_pkg::line_cfg_t cfg;
    uart_line_ctrl_pkg::char9_t    rx_char, rx_out_char;
    uart_line_ctrl #(.CLKS_PER_BIT(CPB)) DUT (.clk(clk), .rst_b(rst_b), .cfg(cfg), .tx_byte_valid(tx_byte_valid),
        .tx_byte_ready(tx_byte_ready), .tx_byte(tx_byte), .tx_line(tx_line), .driver_enable_out(de),
        .tx_busy(tx_busy), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_out_valid(rx_out_valid),
        .rx_out_ready(rx_out_ready), .rx_out_char(rx_out_char), .tx_paused(tx_paused), .addr_matched(addr_matched),
        .rx_disabled(rx_disabled), .rx_overrun(rx_overrun), .rx_overrun_clear(rx_overrun_clear));
    remote_uart #(.CPB(CPB)) far (.clk(clk), .tx_line(tx_line), .nine(cfg.nine_bit),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            errors++;
            wrap_up();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Configuration only changes while the channel is quiet.
    task automatic set_cfg(input logic [2:0] fm, input logic hd, input logic [2:0] pm, input logic pol,
                           input logic [3:0] dly, input logic wide);
        while (tx_busy !== 1'b0) tick(1);
        cfg.flow_mode = fm;
        cfg.half_duplex = hd;
        cfg.pin_mode = pm;
        cfg.de_polarity = pol;
        cfg.turnaround_delay = dly;
        cfg.nine_bit = wide;
        cfg.wide_mode = wide;
        tick(2);
    endtask : set_cfg
    task automatic send_tx(input logic [7:0] b);
        tx_byte = b;
        tx_byte_valid = 1'b1;
        do @(posedge clk); while (tx_byte_ready !== 1'b1);
        #1;
        tx_byte_valid = 1'b0;
        tx_byte = ~b;
        tick(1);
    endtask : send_tx
    task automatic expect_tx(input logic [9:0] e);
        for (int n = 0; n < 900 && far.got.size() == 0; n++) tick(1);
        g = far.got.size() > 0 ? far.got.pop_front() : 10'h000;
        `CHK("tx char", e, g)
    endtask : expect_tx
    task automatic rx(input logic [8:0] c);
        far.send(c);
        tick(1);
    endtask : rx
    task automatic pop_rx(input logic [8:0] e);
        `CHK("rx valid", 1'b1, rx_out_valid)
        `CHK("rx char", e, rx_out_char)
        rx_out_ready = 1'b1;
        tick(1);
        rx_out_ready = 1'b0;
        tick(1);
    endtask : pop_rx
    initial
    begin
        {rst_b, tx_byte_valid, tx_byte, rx_out_ready, rx_overrun_clear} = '0;
        cfg = '0;
        cfg.resume_char = 8'h11;
        cfg.pause_char = 8'h22;
        tick(8);
        rst_b = 1'b1;
        set_cfg(3'h0, 1'b0, 3'h0, 1'b1, 4'h0, 1'b0);
        rx(9'h022);
        pop_rx(9'h022);
        `CHK("paused", 1'b0, tx_paused)
        set_cfg(3'h2, 1'b0, 3'h0, 1'b1, 4'h0, 1'b0);
        send_tx(8'hC3);
        send_tx(8'h3C);
        rx(9'h022);
        `CHK("paused", 1'b1, tx_paused)
        pop_rx(9'h022);
        expect_tx(10'h2C3);
        tick(60);
        `CHK("held", 0, far.got.size())
        rx(9'h011);
        pop_rx(9'h011);
        `CHK("paused", 1'b0, tx_paused)
        expect_tx(10'h23C);
        $display("test pause done");
        for (int k = 0; k < 2; k++)
        begin
            set_cfg(3'h0, 1'b0, k ? 3'h4 : 3'h3, k ? 1'b0 : 1'b1, k ? 4'h3 : 4'h0, 1'b0);
            `CHK("de idle", ~cfg.de_polarity, de)
            send_tx(8'h81);
            expect_tx(10'h281);
            `CHK("de on", cfg.de_polarity, de)
            tick(2 * CPB + 2);
            `CHK("de hold", k ? cfg.de_polarity : ~cfg.de_polarity, de)
            tick(2 * CPB + 4);
            `CHK("de off", ~cfg.de_polarity, de)
        end
        $display("test direction done");
        for (int m = 3; m < 5; m++)
        begin
            set_cfg(3'(m), 1'b0, 3'h0, 1'b1, 4'h0, 1'b0);
            rx(9'h133);
            `CHK("disabled", 1'b1, rx_disabled)
            rx(9'h044);
            `CHK("dropped", 1'b0, rx_out_valid)
            send_tx(8'h5A);
            tick(60);
            `CHK("sent", m == 3 ? 1 : 0, far.got.size())
            rx(m == 3 ? 9'h111 : 9'h122);
            `CHK("matched", 1'b1, addr_matched)
            `CHK("addr kept out", 1'b0, rx_out_valid)
            rx(9'h055);
            pop_rx(9'h055);
            expect_tx(10'h25A);
        end
        $display("test multidrop done");
        set_cfg(3'h0, 1'b1, 3'h0, 1'b1, 4'h0, 1'b0);
        send_tx(8'h99);
        rx(9'h077);
        `CHK("blanked", 1'b0, rx_out_valid)
        expect_tx(10'h299);
        tick(4);
        rx(9'h078);
        pop_rx(9'h078);
        $display("test half duplex done");
        set_cfg(3'h0, 1'b0, 3'h0, 1'b1, 4'h0, 1'b0);
        rx(9'h0A1);
        rx(9'h0A2);
        rx(9'h0A3);
        `CHK("overrun", 1'b1, rx_overrun)
        pop_rx(9'h0A1);
        pop_rx(9'h0A2);
        `CHK("empty", 1'b0, rx_out_valid)
        rx_overrun_clear = 1'b1;
        tick(1);
        rx_overrun_clear = 1'b0;
        tick(1);
        `CHK("overrun clr", 1'b0, rx_overrun)
        $display("test buffer done");
        set_cfg(3'h0, 1'b0, 3'h0, 1'b1, 4'h0, 1'b1);
        send_tx(8'h96);
        send_tx(8'h03);
        expect_tx(10'h396);
        $display("test wide done");
        wrap_up();
    end
endmodule : tb
